// ---- rtl/dfsb_defs.vh ----
// constants of the driver fault status bank
`ifndef DFSB_DEFS_VH
`define DFSB_DEFS_VH

// ----------------------------------------
// status register indices
// ----------------------------------------
`define DFSB_IDX_INJ_ONE 4'h0
`define DFSB_IDX_INJ_TWO 4'h1
`define DFSB_IDX_RELAY_ONE 4'h2
`define DFSB_IDX_RELAY_TWO 4'h3
`define DFSB_IDX_TACH 4'h4
`define DFSB_IDX_LAMP 4'h5
`define DFSB_IDX_UNUSED 4'h6
`define DFSB_IDX_OXY_HEAT 4'h7
`define DFSB_IDX_IGNIT_ONE 4'h8
`define DFSB_IDX_IGNIT_TWO 4'h9
`define DFSB_IDX_WDOG 4'ha
`define DFSB_IDX_PICKUP 4'hb
`define DFSB_IDX_SUPPLY 4'hd
`define DFSB_IDX_ONIND 4'he
`define DFSB_IDX_MODEL 4'hf

// ----------------------------------------
// fault field positions
// ----------------------------------------
`define DFSB_BIT_ANY 7
`define DFSB_BIT_OPEN_LOAD 3
`define DFSB_BIT_OVER_CUR 2
`define DFSB_BIT_OVER_TEMP 1
`define DFSB_BIT_SHORT_GND 0
`define DFSB_BIT_SELF_TEST 7

// ----------------------------------------
// reset values and implemented-bit masks
// ----------------------------------------
`define DFSB_RST_FAULT 8'h00
`define DFSB_MASK_FULL 4'hf
`define DFSB_MASK_TACH 4'he
`define DFSB_MASK_PRE 4'hc
`define DFSB_RST_PULLDN 9'h1ff

// ----------------------------------------
// open-load filter timing
// ----------------------------------------
`define DFSB_OL_FILT_MIN_US 100
`define DFSB_OL_FILT_MAX_US 450
`define DFSB_CLK_MHZ 20
`define DFSB_OL_FILT_CYC (`DFSB_OL_FILT_MIN_US * `DFSB_CLK_MHZ)

`endif

// ---- rtl/dfsb_fault_bank.v ----
// driver fault status bank with off-state open-load detection
`timescale 1ns/100ps
// Overview of operation
// - driver fault register: bit7 summary, 3 open load, 2 overcurrent, 1 overtemp, 0 short
// - indices: injectors 0/1, relays 2/3, tach 4, lamp 5, heater 7, ignition 8/9
// - tachometer register has no short-to-ground flag; bit 0 reads zero
// - heater and ignition pre-drivers report only open load and overcurrent
// - open load sensed only while output commanded off, via drain comparator
// - open-load bit reads zero while that output's pull-down is disabled
// - pull-downs enabled at reset; off only in sleep or by host
// - open-load filter between 100 and 450 microseconds masks switching transients
// - chip select rising edge restarts timer; comparator accepted only after expiry
// - open-load flag stays latched until the host has read it or that output's pull-down is disabled
// - in low supply commands still execute; status may be wrong
`include "dfsb_defs.vh"

module dfsb_fault_bank #(
	parameter OL_FILT_CYC = `DFSB_OL_FILT_CYC,
	parameter [2:0] MODEL_CODE = 3'h1,
	parameter [4:0] REV_CODE = 5'h01
) (
	input wire core_clk,
	input wire sys_rst,
	input wire chip_select_n,
	input wire rd_strobe,
	input wire wr_strobe,
	input wire [3:0] reg_index,
	input wire [7:0] wr_data,
	input wire [8:0] output_cmd_on,
	input wire [8:0] open_load_cmp,
	input wire [8:0] over_current_in,
	input wire [8:0] over_temp_in,
	input wire [8:0] short_to_ground_in,
	input wire [8:0] pulldown_off_req,
	input wire sleep_mode,
	input wire low_supply,
	input wire [7:0] watchdog_in,
	input wire [7:0] pickup_kline_in,
	input wire [7:0] supply_sys_in,
	output reg [7:0] rd_data_ff,
	output reg [8:0] pulldown_en_ff,
	output reg power_on_self_test_ff,
	output reg status_unsure_ff
);

	// ----------------------------------------
	// channel numbering and helpers
	// ----------------------------------------
	// channels 0..8: injectors, relays, tach, lamp, heater, ignitions
	localparam [5:0] OL_FILT_W = 6'd16;

	// implemented fault bits per channel
	function [3:0] impl_mask;
		input integer ch;
		begin
			if (ch == 4)
				impl_mask = `DFSB_MASK_TACH;
			else if (ch >= 6)
				impl_mask = `DFSB_MASK_PRE;
			else
				impl_mask = `DFSB_MASK_FULL;
		end
	endfunction

	// index to channel decode, 4'hf when no channel
	function [3:0] idx_to_ch;
		input [3:0] idx;
		begin
			case (idx)
				`DFSB_IDX_INJ_ONE: idx_to_ch = 4'h0;
				`DFSB_IDX_INJ_TWO: idx_to_ch = 4'h1;
				`DFSB_IDX_RELAY_ONE: idx_to_ch = 4'h2;
				`DFSB_IDX_RELAY_TWO: idx_to_ch = 4'h3;
				`DFSB_IDX_TACH: idx_to_ch = 4'h4;
				`DFSB_IDX_LAMP: idx_to_ch = 4'h5;
				`DFSB_IDX_OXY_HEAT: idx_to_ch = 4'h6;
				`DFSB_IDX_IGNIT_ONE: idx_to_ch = 4'h7;
				`DFSB_IDX_IGNIT_TWO: idx_to_ch = 4'h8;
				default: idx_to_ch = 4'hf;
			endcase
		end
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	reg cs_meta_ff;
	reg cs_sync_ff;
	reg cs_prev_ff;
	reg [8:0] ol_meta_ff;
	reg [8:0] ol_sync_ff;

	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cs_meta_ff <= 1'b1;
			cs_sync_ff <= 1'b1;
			cs_prev_ff <= 1'b1;
			ol_meta_ff <= 9'h000;
			ol_sync_ff <= 9'h000;
		end else begin
			cs_meta_ff <= chip_select_n;
			cs_sync_ff <= cs_meta_ff;
			cs_prev_ff <= cs_sync_ff;
			ol_meta_ff <= open_load_cmp;
			ol_sync_ff <= ol_meta_ff;
		end
	end

	wire cs_rise = cs_sync_ff & ~cs_prev_ff;
	wire [3:0] rd_ch = idx_to_ch(reg_index);

	// ----------------------------------------
	// pull-down enables and self-test bit
	// ----------------------------------------
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pulldown_en_ff <= `DFSB_RST_PULLDN;
			power_on_self_test_ff <= 1'b0;
			status_unsure_ff <= 1'b0;
		end else begin
			pulldown_en_ff <= ~pulldown_off_req & {9{~sleep_mode}};
			status_unsure_ff <= low_supply;
			if (wr_strobe && reg_index == `DFSB_IDX_MODEL)
				power_on_self_test_ff <= wr_data[`DFSB_BIT_SELF_TEST];
		end
	end

	// ----------------------------------------
	// per-channel fault latches
	// ----------------------------------------
	wire [3:0] flt_bits [0:8];
	wire [8:0] any_flt;

	genvar g;
	generate
		for (g = 0; g < 9; g = g + 1) begin : g_ch
			reg [OL_FILT_W-1:0] filt_cnt_ff;
			reg [OL_FILT_W-1:0] nxt_filt_cnt;
			reg [3:0] flt_ff;
			reg [3:0] nxt_flt;
			reg [3:0] raw;
			wire ol_allowed;
			wire clr;

			// filter counter restarts on cs rise, while output on or while pull-down disabled
			always @* begin
				if (cs_rise || output_cmd_on[g] || !pulldown_en_ff[g])
					nxt_filt_cnt = {OL_FILT_W{1'b0}};
				else if (filt_cnt_ff != OL_FILT_CYC[OL_FILT_W-1:0])
					nxt_filt_cnt = filt_cnt_ff + 1'b1;
				else
					nxt_filt_cnt = filt_cnt_ff;
			end

			assign ol_allowed = (filt_cnt_ff == OL_FILT_CYC[OL_FILT_W-1:0]);
			assign clr = rd_strobe && (rd_ch == g);

			always @* begin
				raw[`DFSB_BIT_OPEN_LOAD] = ol_allowed & ~output_cmd_on[g] & ol_sync_ff[g];
				raw[`DFSB_BIT_OVER_CUR] = over_current_in[g];
				raw[`DFSB_BIT_OVER_TEMP] = over_temp_in[g];
				raw[`DFSB_BIT_SHORT_GND] = short_to_ground_in[g];
				raw = raw & impl_mask(g);
				// set wins over the read clear
				nxt_flt = (clr ? 4'h0 : flt_ff) | raw;
				if (!pulldown_en_ff[g])
					nxt_flt[`DFSB_BIT_OPEN_LOAD] = 1'b0;
			end

			always @(posedge core_clk or posedge sys_rst) begin
				if (sys_rst) begin
					filt_cnt_ff <= {OL_FILT_W{1'b0}};
					flt_ff <= 4'h0;
				end else begin
					filt_cnt_ff <= nxt_filt_cnt;
					flt_ff <= nxt_flt;
				end
			end

			assign flt_bits[g] = flt_ff;
			assign any_flt[g] = |flt_ff;
		end
	endgenerate

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	reg [7:0] nxt_rd_data;

	always @* begin
		nxt_rd_data = rd_data_ff;
		if (rd_strobe) begin
			if (rd_ch != 4'hf)
				nxt_rd_data = {any_flt[rd_ch], 3'h0, flt_bits[rd_ch]};
			else begin
				case (reg_index)
					`DFSB_IDX_WDOG: nxt_rd_data = watchdog_in;
					`DFSB_IDX_PICKUP: nxt_rd_data = pickup_kline_in;
					`DFSB_IDX_SUPPLY: nxt_rd_data = supply_sys_in;
					`DFSB_IDX_ONIND: nxt_rd_data = {output_cmd_on[0], output_cmd_on[1], output_cmd_on[2],
						output_cmd_on[3], output_cmd_on[5], output_cmd_on[7], output_cmd_on[8],
						output_cmd_on[6]};
					`DFSB_IDX_MODEL: nxt_rd_data = {MODEL_CODE, REV_CODE}; // arbitrary identity values
					default: nxt_rd_data = `DFSB_RST_FAULT;
				endcase
			end
		end
	end

	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			rd_data_ff <= `DFSB_RST_FAULT;
		else
			rd_data_ff <= nxt_rd_data;
	end

endmodule

// ---- tb/dfsb_props_properties.sv ----
// assertion checker of the fault bank
`timescale 1ns/100ps
module dfsb_props(
	input wire core_clk,
	input wire sys_rst,
	input wire rd_strobe,
	input wire wr_strobe,
	input wire [3:0] reg_index,
	input wire [8:0] pulldown_off_req,
	input wire sleep_mode,
	input wire low_supply,
	input wire [7:0] rd_data_ff,
	input wire [8:0] pulldown_en_ff,
	input wire power_on_self_test_ff,
	input wire status_unsure_ff
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	wire drv = rd_strobe && reg_index <= 4'h9;
	wire gap = rd_strobe && (reg_index == 4'h6 || reg_index == 4'hc);
	AST_FMT: assert property (drv |=> rd_data_ff[6:4] == 3'h0) else $error("spare bits");
	AST_SUM: assert property (drv |=> rd_data_ff[7] == |rd_data_ff[3:0]) else $error("summary");
	AST_TACH: assert property (rd_strobe && reg_index == 4'h4 |=> !rd_data_ff[0]) else $error("tach");
	AST_PRE: assert property (drv && reg_index > 4'h6 |=> rd_data_ff[1:0] == 2'h0) else $error("pre");
	AST_GAP: assert property (gap |=> rd_data_ff == 8'h00) else $error("gap");
	AST_PD: assert property (pulldown_en_ff == ~$past(pulldown_off_req | {9{sleep_mode}})) else $error("pd");
	AST_UNS: assert property (status_unsure_ff == $past(low_supply)) else $error("unsure");
	AST_WR: assert property (wr_strobe && reg_index != 4'hf |=> $stable(power_on_self_test_ff)) else $error("wr");
	cover property (drv ##1 rd_data_ff[7]);
	cover property (gap);
	cover property (sleep_mode);
endmodule
bind dfsb_fault_bank dfsb_props u_props(.*);

// ---- tb/dfsb_host.sv ----
// host side model driving the register port
`timescale 1ns/100ps
module dfsb_host(
	input wire core_clk,
	input wire [7:0] rd_data_ff,
	output reg chip_select_n,
	output reg rd_strobe,
	output reg wr_strobe,
	output reg [3:0] reg_index,
	output reg [7:0] wr_data
);
	initial {chip_select_n, rd_strobe, wr_strobe, reg_index, wr_data} = 15'h4000;
	task xfer(input rd, input [3:0] idx, input [7:0] d, output [7:0] q);
		@(posedge core_clk);
		chip_select_n <= 1'b0;
		rd_strobe <= rd;
		wr_strobe <= !rd;
		reg_index <= idx;
		wr_data <= d;
		@(posedge core_clk);
		{rd_strobe, wr_strobe} <= 2'h0;
		chip_select_n <= 1'b1;
		reg_index <= ~idx;
		wr_data <= ~d;
		#1 q = rd_data_ff;
	endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench of the fault bank
`timescale 1ns/100ps
module tb_top;
	reg core_clk = 1'b0;
	reg sys_rst = 1'b1;
	reg [8:0] on = 9'h0, olc = 9'h0, oc = 9'h0, ot = 9'h0, sg = 9'h0, pdo = 9'h0;
	reg slp = 1'b0, lows = 1'b0;
	wire cs_n, rs, ws, power_on_self_test, uns;
	wire [3:0] ix;
	wire [7:0] wd, rd;
	wire [8:0] pde;
	reg [7:0] q;
	integer failures = 0, cmp_count = 0, i;
	always #25 core_clk = ~core_clk;
	dfsb_fault_bank #(.OL_FILT_CYC(20)) dut(.core_clk(core_clk), .sys_rst(sys_rst), .chip_select_n(cs_n),
		.rd_strobe(rs), .wr_strobe(ws), .reg_index(ix), .wr_data(wd), .output_cmd_on(on), .open_load_cmp(olc),
		.over_current_in(oc), .over_temp_in(ot), .short_to_ground_in(sg), .pulldown_off_req(pdo), .sleep_mode(slp),
		.low_supply(lows), .watchdog_in(8'h5a), .pickup_kline_in(8'ha5), .supply_sys_in(8'h3c), .rd_data_ff(rd),
		.pulldown_en_ff(pde), .power_on_self_test_ff(power_on_self_test), .status_unsure_ff(uns));
	dfsb_host host(.core_clk(core_clk), .rd_data_ff(rd), .chip_select_n(cs_n), .rd_strobe(rs), .wr_strobe(ws),
		.reg_index(ix), .wr_data(wd));
	task chk(input [8:0] g, input [8:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task rc(input [3:0] x, input [7:0] e);
		host.xfer(1'b1, x, 8'h00, q);
		chk({1'b0, q}, {1'b0, e});
	endtask
	task t_reset;
		chk(pde, 9'h1ff);
		for (i = 0; i < 16; i++) rc(i[3:0], i == 10 ? 8'h5a : i == 11 ? 8'ha5 : i == 13 ? 8'h3c : i == 15 ? 8'h21 : 8'h00);
	endtask
	task t_faults;
		@(posedge core_clk);
		{oc, ot, sg} <= {27{1'b1}};
		@(posedge core_clk);
		{oc, ot, sg} <= 27'h0;
		for (i = 0; i < 10; i++) begin
			rc(i[3:0], i == 4 ? 8'h86 : i > 6 ? 8'h84 : i == 6 ? 8'h00 : 8'h87);
			rc(i[3:0], 8'h00);
		end
	endtask
	task t_open_load;
		@(posedge core_clk);
		olc <= 9'h003;
		on <= 9'h002;
		repeat (10) @(posedge core_clk);
		rc(4'h0, 8'h00);
		repeat (40) @(posedge core_clk);
		olc <= 9'h000;
		rc(4'h1, 8'h00);
		rc(4'h0, 8'h88);
		rc(4'h0, 8'h00);
	endtask
	task t_pulldown;
		@(posedge core_clk);
		on <= 9'h000;
		olc <= 9'h004;
		pdo <= 9'h004;
		repeat (40) @(posedge core_clk);
		rc(4'h2, 8'h00);
		chk(pde, 9'h1fb);
		@(posedge core_clk);
		slp <= 1'b1;
		lows <= 1'b1;
		pdo <= 9'h000;
		repeat (2) @(posedge core_clk);
		#1 chk(pde, 9'h000);
		chk({8'h00, uns}, 9'h001);
		@(posedge core_clk);
		slp <= 1'b0;
		olc <= 9'h000;
	endtask
	task t_write;
		host.xfer(1'b0, 4'h2, 8'hff, q);
		rc(4'h2, 8'h00);
		host.xfer(1'b0, 4'hf, 8'h80, q);
		chk({8'h00, power_on_self_test}, 9'h001);
		host.xfer(1'b0, 4'hf, 8'h00, q);
		chk({8'h00, power_on_self_test}, 9'h000);
	endtask
	task end_sim;
		$display("failures %0d compares %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_reset;
		t_faults;
		t_open_load;
		t_pulldown;
		t_write;
		end_sim;
	end
	initial begin
		#60000;
		failures++;
		end_sim;
	end
endmodule
